// [include/frw_pkg.sv]
// Purpose: shared constants and types of the flash row write latch sequencer
// Assumes: 20 MHz system clock
// Notes:   register indices are the core-side register numbers, apb byte address is index * 4
package frw_pkg;
  // ****************************************************************
  // geometry and data
  // ****************************************************************
  localparam int unsigned FRW_WORD_W    = 14;
  localparam int unsigned FRW_COL_W     = 5;
  localparam int unsigned FRW_ROW_W     = 10;
  localparam int unsigned FRW_ADDR_W    = FRW_ROW_W + FRW_COL_W;
  localparam int unsigned FRW_LATCHES   = 32;
  localparam logic [13:0] FRW_BLANK     = 14'h3fff;
  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [2:0]  FRW_IDX_ADDR_LO = 3'h0;
  localparam logic [2:0]  FRW_IDX_ADDR_HI = 3'h1;
  localparam logic [2:0]  FRW_IDX_DATA_LO = 3'h2;
  localparam logic [2:0]  FRW_IDX_DATA_HI = 3'h3;
  localparam logic [2:0]  FRW_IDX_CTRL    = 3'h4;
  localparam logic [2:0]  FRW_IDX_UNLOCK  = 3'h5;
  // ****************************************************************
  // flash_control bit positions and reset values
  // ****************************************************************
  localparam int unsigned FRW_CTL_RD    = 0;
  localparam int unsigned FRW_CTL_WR    = 1;
  localparam int unsigned FRW_CTL_PROGRAM_ENABLE  = 2;
  localparam int unsigned FRW_CTL_WRERR = 3;
  localparam int unsigned FRW_CTL_FREE  = 4;
  localparam int unsigned FRW_CTL_LATCH_ONLY_SELECT  = 5;
  localparam int unsigned FRW_CTL_CONFIG_SPACE_SELECT  = 6;
  localparam logic [7:0]  FRW_RST_BYTE  = 8'h00;
  localparam logic [7:0]  FRW_UNLOCK_1  = 8'h55;
  localparam logic [7:0]  FRW_UNLOCK_2  = 8'haa;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned FRW_CLK_MHZ      = 20;
  localparam int unsigned FRW_PROG_TIME_US = 2000;
  localparam int unsigned FRW_PROG_CYCLES  = FRW_PROG_TIME_US * FRW_CLK_MHZ;
  localparam int unsigned FRW_SLOTS        = 2;
  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [1:0] {
    FRW_ST_IDLE = 2'b00,
    FRW_ST_SLOT = 2'b01,
    FRW_ST_BUSY = 2'b10
  } frw_state_t;
  typedef enum logic [1:0] {
    FRW_UNL_IDLE  = 2'b00,
    FRW_UNL_GOT1  = 2'b01,
    FRW_UNL_ARMED = 2'b10
  } frw_unl_t;
endpackage

// [include/frw_if.sv]
// Purpose: register path between the core and the flash sequencer
// Assumes: one clock, all signals change after a rising edge
// Notes:   reg_wr and reg_rd are one-cycle pulses
`timescale 1ns/100ps
interface frw_if;
  logic       reg_wr;
  logic       reg_rd;
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       seq_break;
  logic       core_hold;
  modport dev  (input reg_wr, reg_rd, reg_idx, reg_wdata, seq_break,
                output reg_rdata, core_hold);
  modport core (output reg_wr, reg_rd, reg_idx, reg_wdata, seq_break,
                input reg_rdata, core_hold);
endinterface

// [design/frw_ctrl.sv]
// Purpose: flash row self-write sequencer, write latches and program flash array
// Assumes: core stalls while core_hold is high, so no register access lands mid operation
// Notes:   array contents are not reset; programming can only clear bits
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
module frw_ctrl
  import frw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = FRW_PROG_CYCLES
) (
  // system
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // core side
  frw_if.dev                         bus,
  // array read port
  input  wire logic [FRW_ADDR_W-1:0] rd_addr,
  output logic      [FRW_WORD_W-1:0] rd_data
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [FRW_WORD_W-1:0] mem_q [2**FRW_ADDR_W];
  logic [FRW_WORD_W-1:0] latch_q [FRW_LATCHES];
  logic [7:0]            addr_lo_q;
  logic [6:0]            addr_hi_q;
  logic [7:0]            data_lo_q;
  logic [5:0]            data_hi_q;
  logic                  config_space_select_q;
  logic                  latch_only_select_q;
  logic                  free_q;
  logic                  wrerr_q;
  logic                  program_enable_q;
  logic                  wr_q;
  logic                  hold_q;
  logic                  op_erase_q;
  logic                  op_latch_q;
  logic                  slot_q;
  logic [15:0]           tmr_q;
  logic [FRW_WORD_W-1:0] rd_data_q;
  frw_state_t            st_q;
  frw_unl_t              unl_q;
  frw_unl_t              unl_d;
  // ****************************************************************
  // decode
  // ****************************************************************
  wire                  access   = bus.reg_wr | bus.reg_rd;
  wire                  wr_unl   = bus.reg_wr & (bus.reg_idx == FRW_IDX_UNLOCK);
  wire                  wr_ctl   = bus.reg_wr & (bus.reg_idx == FRW_IDX_CTRL);
  wire [7:0]            wd       = bus.reg_wdata;
  wire                  trig_try = wr_ctl & wd[FRW_CTL_WR] & (st_q == FRW_ST_IDLE);
  // trigger needs an intact unlock, program enable and program space
  wire                  trig_ok  = trig_try & (unl_q == FRW_UNL_ARMED) & ~bus.seq_break
                                   & wd[FRW_CTL_PROGRAM_ENABLE] & ~wd[FRW_CTL_CONFIG_SPACE_SELECT];
  wire                  trig_bad = trig_try & ~trig_ok;
  wire                  rd_go    = wr_ctl & wd[FRW_CTL_RD] & ~wd[FRW_CTL_CONFIG_SPACE_SELECT];
  wire [FRW_ROW_W-1:0]  row      = {addr_hi_q, addr_lo_q[7:5]};
  wire [FRW_COL_W-1:0]  col      = addr_lo_q[4:0];
  wire [FRW_ADDR_W-1:0] cur_addr = {row, col};
  wire                  slots_end = (st_q == FRW_ST_SLOT) & slot_q;
  wire                  commit   = (st_q == FRW_ST_BUSY)
                                   & (tmr_q == 16'(PROG_CYCLES - 1));
  wire [7:0]            ctl_rd   = {1'b1, config_space_select_q, latch_only_select_q, free_q, wrerr_q, program_enable_q, wr_q, 1'b0};

  assign rd_data       = rd_data_q;
  assign bus.core_hold = hold_q;
  assign bus.reg_rdata = (bus.reg_idx == FRW_IDX_ADDR_LO) ? addr_lo_q :
                         (bus.reg_idx == FRW_IDX_ADDR_HI) ? {1'b1, addr_hi_q} :
                         (bus.reg_idx == FRW_IDX_DATA_LO) ? data_lo_q :
                         (bus.reg_idx == FRW_IDX_DATA_HI) ? {2'b00, data_hi_q} :
                         (bus.reg_idx == FRW_IDX_CTRL)    ? ctl_rd : FRW_RST_BYTE;

  // ****************************************************************
  // unlock tracker
  // ****************************************************************
  // any other access or an interrupt in between disarms the sequence
  always_comb begin
    unl_d = unl_q;
    if (bus.seq_break) begin
      unl_d = FRW_UNL_IDLE;
    end else if (wr_unl) begin
      if (wd == FRW_UNLOCK_1) begin
        unl_d = FRW_UNL_GOT1;
      end else if (wd == FRW_UNLOCK_2 && unl_q == FRW_UNL_GOT1) begin
        unl_d = FRW_UNL_ARMED;
      end else begin
        unl_d = FRW_UNL_IDLE;
      end
    end else if (access) begin
      unl_d = FRW_UNL_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_q <= FRW_UNL_IDLE;
    end else begin
      unl_q <= unl_d;
    end
  end

  // ****************************************************************
  // address, data and control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_lo_q <= FRW_RST_BYTE;
      addr_hi_q <= 7'h00;
      data_lo_q <= FRW_RST_BYTE;
      data_hi_q <= 6'h00;
      config_space_select_q    <= 1'b0;
      latch_only_select_q    <= 1'b0;
      program_enable_q    <= 1'b0;
    end else begin
      if (bus.reg_wr && bus.reg_idx == FRW_IDX_ADDR_LO) begin
        addr_lo_q <= wd;
      end
      if (bus.reg_wr && bus.reg_idx == FRW_IDX_ADDR_HI) begin
        addr_hi_q <= wd[6:0];
      end
      if (rd_go) begin
        {data_hi_q, data_lo_q} <= mem_q[cur_addr];
      end else if (bus.reg_wr && bus.reg_idx == FRW_IDX_DATA_LO) begin
        data_lo_q <= wd;
      end else if (bus.reg_wr && bus.reg_idx == FRW_IDX_DATA_HI) begin
        data_hi_q <= wd[5:0];
      end
      if (wr_ctl) begin
        config_space_select_q <= wd[FRW_CTL_CONFIG_SPACE_SELECT];
        latch_only_select_q <= wd[FRW_CTL_LATCH_ONLY_SELECT];
        program_enable_q <= wd[FRW_CTL_PROGRAM_ENABLE];
      end
    end
  end

  // error flag: a refused trigger sets it and wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrerr_q <= 1'b0;
    end else if (trig_bad) begin
      wrerr_q <= 1'b1;
    end else if (wr_ctl) begin
      wrerr_q <= wd[FRW_CTL_WRERR];
    end
  end

  // ****************************************************************
  // operation sequencer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= FRW_ST_IDLE;
      wr_q       <= 1'b0;
      free_q     <= 1'b0;
      hold_q     <= 1'b0;
      op_erase_q <= 1'b0;
      op_latch_q <= 1'b0;
      slot_q     <= 1'b0;
      tmr_q      <= 16'h0000;
    end else begin
      unique case (st_q)
        FRW_ST_IDLE: begin
          if (wr_ctl) begin
            free_q <= wd[FRW_CTL_FREE];
          end
          if (trig_ok) begin
            st_q       <= FRW_ST_SLOT;
            wr_q       <= 1'b1;
            hold_q     <= 1'b1;
            slot_q     <= 1'b0;
            op_erase_q <= wd[FRW_CTL_FREE];
            op_latch_q <= wd[FRW_CTL_LATCH_ONLY_SELECT] & ~wd[FRW_CTL_FREE];
          end
        end
        FRW_ST_SLOT: begin
          slot_q <= 1'b1;
          if (slots_end && op_latch_q) begin
            st_q   <= FRW_ST_IDLE;
            wr_q   <= 1'b0;
            hold_q <= 1'b0;
          end else if (slots_end) begin
            st_q  <= FRW_ST_BUSY;
            tmr_q <= 16'h0000;
          end
        end
        FRW_ST_BUSY: begin
          tmr_q <= tmr_q + 16'h0001;
          if (commit) begin
            st_q   <= FRW_ST_IDLE;
            wr_q   <= 1'b0;
            free_q <= 1'b0;
            hold_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // write latches
  // ****************************************************************
  // erase leaves the latches alone except for the final blanking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FRW_LATCHES; i++) begin
        latch_q[i] <= FRW_BLANK;
      end
    end else if (commit) begin
      for (int i = 0; i < FRW_LATCHES; i++) begin
        latch_q[i] <= FRW_BLANK;
      end
    end else if (trig_ok && !wd[FRW_CTL_FREE]) begin
      latch_q[col] <= {data_hi_q, data_lo_q};
    end
  end

  // ****************************************************************
  // flash array
  // ****************************************************************
  // a write only pulls bits low, so a non-blank word cannot be restored
  always_ff @(posedge pclk) begin
    if (commit) begin
      for (int i = 0; i < FRW_LATCHES; i++) begin
        if (op_erase_q) begin
          mem_q[{row, FRW_COL_W'(i)}] <= FRW_BLANK;
        end else begin
          mem_q[{row, FRW_COL_W'(i)}] <= mem_q[{row, FRW_COL_W'(i)}] & latch_q[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= FRW_BLANK;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

// [design/frw_core.sv]
// Purpose: core end, turns apb transfers into register accesses of the sequencer
// Assumes: apb master keeps the request stable until pready
// Notes:   a stalled sequencer stretches the apb access phase
`timescale 1ns/100ps
module frw_core
  import frw_pkg::*;
(
  // system
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt arriving at the core
  input  wire logic        irq_pending,
  // sequencer side
  frw_if.core              bus
);
  // ****************************************************************
  // decode
  // ****************************************************************
  logic [1:0]  ph_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        reg_wr_q;
  logic        reg_rd_q;
  logic [2:0]  idx_q;
  logic [7:0]  wdata_q;
  logic        brk_q;

  wire [2:0] idx    = paddr[4:2];
  wire       mapped = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0) & (idx <= FRW_IDX_UNLOCK);
  wire       req    = psel & penable & ~pready_q;

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign bus.reg_wr    = reg_wr_q;
  assign bus.reg_rd    = reg_rd_q;
  assign bus.reg_idx   = idx_q;
  assign bus.reg_wdata = wdata_q;
  assign bus.seq_break = brk_q;

  // ****************************************************************
  // transfer sequencing
  // ****************************************************************
  // phase 0 issues, 1 lets the sequencer react, 2 waits out any stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q      <= 2'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      reg_wr_q  <= 1'b0;
      reg_rd_q  <= 1'b0;
      idx_q     <= 3'h0;
      wdata_q   <= 8'h00;
      brk_q     <= 1'b0;
    end else begin
      brk_q    <= irq_pending;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      pready_q <= 1'b0;
      if (ph_q == 2'h0 && req && !mapped) begin
        pready_q  <= 1'b1;
        pslverr_q <= 1'b1;
        prdata_q  <= 32'h0000_0000;
      end else if (ph_q == 2'h0 && req) begin
        reg_wr_q <= pwrite;
        reg_rd_q <= ~pwrite;
        idx_q    <= idx;
        wdata_q  <= pwdata[7:0];
        ph_q     <= 2'h1;
      end else if (ph_q == 2'h1) begin
        ph_q <= 2'h2;
      end else if (ph_q == 2'h2 && !bus.core_hold) begin
        pready_q  <= 1'b1;
        pslverr_q <= 1'b0;
        prdata_q  <= {24'h000000, bus.reg_rdata};
        ph_q      <= 2'h0;
      end
    end
  end
endmodule

// [tb/frw_properties.sv]
// Purpose: checks on the register path between core and sequencer
// Assumes: one clock, core_hold is the only stall
// Notes:   arming is tracked here from the pulses, not read from the design
`timescale 1ns/100ps
module frw_properties
  import frw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = FRW_PROG_CYCLES
) (
  // system
  input wire logic       pclk,
  input wire logic       presetn,
  // register path
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       seq_break,
  input wire logic       core_hold
);
  // ****************************************************************
  // arming and stall tracking
  // ****************************************************************
  logic        got1_q;
  logic        armed_q;
  logic        prog_q;
  logic [31:0] hold_q;
  wire acc     = reg_wr | reg_rd;
  wire unl_w   = reg_wr && reg_idx == FRW_IDX_UNLOCK;
  wire ctl_w   = reg_wr && reg_idx == FRW_IDX_CTRL && reg_wdata[FRW_CTL_WR];
  wire ena     = reg_wdata[FRW_CTL_PROGRAM_ENABLE] && !reg_wdata[FRW_CTL_CONFIG_SPACE_SELECT];
  wire good    = ctl_w && armed_q && !seq_break && ena;
  wire is_prog = !reg_wdata[FRW_CTL_LATCH_ONLY_SELECT] || reg_wdata[FRW_CTL_FREE];
  // any access or break in between disarms, a read too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got1_q  <= 1'b0;
      armed_q <= 1'b0;
      prog_q  <= 1'b0;
      hold_q  <= 32'h0;
    end else begin
      got1_q  <= !seq_break && (acc ? unl_w && reg_wdata == FRW_UNLOCK_1 : got1_q);
      armed_q <= !seq_break && (acc ? got1_q && unl_w && reg_wdata == FRW_UNLOCK_2 : armed_q);
      prog_q  <= good ? is_prog : prog_q;
      hold_q  <= core_hold ? hold_q + 32'h1 : 32'h0;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_latch_trig;
    good && !is_prog;
  endsequence
  sequence s_slots;
    core_hold [*2] ##1 !core_hold;
  endsequence
  AST_HOLD_AFTER_TRIGGER: assert property (good |=> core_hold)
    else $error("no stall after armed trigger");
  AST_LATCH_SLOTS: assert property (s_latch_trig |=> s_slots)
    else $error("latch load slots wrong");
  AST_NO_HOLD_UNARMED: assert property (ctl_w && !armed_q |=> !core_hold)
    else $error("unarmed trigger acted");
  AST_NO_HOLD_DISABLED: assert property (ctl_w && !reg_wdata[FRW_CTL_PROGRAM_ENABLE] |=> !core_hold)
    else $error("trigger acted without enable");
  AST_STALL_LENGTH: assert property ($fell(core_hold) |-> hold_q == (prog_q ? PROG_CYCLES + 2 : 2))
    else $error("stall length wrong");
  AST_STALL_BOUND: assert property (core_hold |-> hold_q < PROG_CYCLES + 2)
    else $error("stall too long");
  AST_HOLD_CAUSE: assert property ($rose(core_hold) |-> $past(good))
    else $error("stall without armed trigger");
  AST_TRIGGER_CLEARED: assert property (reg_rd && reg_idx == FRW_IDX_CTRL |-> !reg_rdata[FRW_CTL_WR])
    else $error("trigger bit left set");
  AST_DATA_HIGH_BITS: assert property (reg_rd && reg_idx == FRW_IDX_DATA_HI |-> reg_rdata[7:6] == 2'b00)
    else $error("data high top bits set");
endmodule

// [tb/test_flash_row_write_latch_sequencer.sv]
// Purpose: both ends joined, driven over apb, array checked at the read port
// Assumes: short programming time in simulation
// Notes:   rows 0x009 and 0x00a are erased before any program, the array is not reset
`timescale 1ns/100ps
module test_flash_row_write_latch_sequencer
  import frw_pkg::*;
;
  localparam int unsigned PC = 20;
  localparam logic [7:0] A_LO = 8'h00, A_HI = 8'h04, D_LO = 8'h08, D_HI = 8'h0c;
  localparam logic [7:0] CTL = 8'h10, UNL = 8'h14;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_pending, ev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [14:0] rd_addr;
  logic [13:0] rd_data;
  int          n_errors, checked;
  frw_if link ();
  frw_ctrl #(.PROG_CYCLES(PC)) u_frw_ctrl (.pclk(pclk), .presetn(presetn), .bus(link),
    .rd_addr(rd_addr), .rd_data(rd_data));
  frw_core u_frw_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pending(irq_pending), .bus(link));
  frw_properties #(.PROG_CYCLES(PC)) u_frw_properties (.pclk(pclk), .presetn(presetn),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_idx(link.reg_idx),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .seq_break(link.seq_break),
    .core_hold(link.core_hold));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // waits on pready only, a stalled sequencer stretches the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    apb(1'b0, a, 8'h00);
    check(name, rv, {24'h0, exp});
  endtask
  task automatic trig(input logic [7:0] c);
    apb(1'b1, UNL, FRW_UNLOCK_1);
    apb(1'b1, UNL, FRW_UNLOCK_2);
    apb(1'b1, CTL, c);
  endtask
  // top bits of data high are set on purpose, they must be dropped
  task automatic load(input logic [4:0] col, input logic [13:0] w, input logic [7:0] c);
    apb(1'b1, A_LO, {3'h1, col});
    apb(1'b1, D_LO, w[7:0]);
    apb(1'b1, D_HI, {2'b11, w[13:8]});
    trig(c);
  endtask
  task automatic arr_at(input logic [14:0] a, input logic [13:0] exp);
    rd_addr <= a;
    @(posedge pclk);
    @(posedge pclk);
    check("array word", {18'h0, rd_data}, {18'h0, exp});
  endtask
  task automatic arr(input logic [4:0] col, input logic [13:0] exp);
    arr_at({7'h01, 3'h1, col}, exp);
  endtask
  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, irq_pending} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd_addr = 15'h0;
    n_errors = 0;
    checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTL, 8'h80, "control reset");
    rd(A_HI, 8'h80, "addr high reset");
    rd(UNL, 8'h00, "unlock reads");
    apb(1'b0, 8'h18, 8'h00);
    check("unmapped error", {31'h0, ev}, 32'h1);
    apb(1'b1, A_HI, 8'h01);
    apb(1'b1, A_LO, 8'h25);
    trig(8'h16);
    apb(1'b1, A_LO, 8'h45);
    trig(8'h16);
    arr(5'd0, FRW_BLANK);
    arr(5'd31, FRW_BLANK);
    rd(CTL, 8'h84, "erase done");
    apb(1'b1, CTL, 8'h24);
    load(5'd0, 14'h1234, 8'h26);
    rd(D_HI, 8'h12, "data high");
    rd(CTL, 8'ha4, "latch done");
    apb(1'b1, A_LO, 8'h25);
    apb(1'b1, UNL, FRW_UNLOCK_1);
    apb(1'b0, CTL, 8'h00);
    apb(1'b1, UNL, FRW_UNLOCK_2);
    apb(1'b1, CTL, 8'h26);
    rd(CTL, 8'hac, "error flag");
    apb(1'b1, CTL, 8'h24);
    apb(1'b1, A_LO, 8'h26);
    apb(1'b1, UNL, FRW_UNLOCK_1);
    irq_pending <= 1'b1;
    @(posedge pclk);
    irq_pending <= 1'b0;
    @(posedge pclk);
    apb(1'b1, UNL, FRW_UNLOCK_2);
    apb(1'b1, CTL, 8'h26);
    apb(1'b1, CTL, 8'h20);
    load(5'd7, 14'h0000, 8'h22);
    apb(1'b1, CTL, 8'h24);
    load(5'd31, 14'h0abc, 8'h26);
    load(5'd1, 14'h2001, 8'h06);
    arr(5'd0, 14'h1234);
    arr(5'd1, 14'h2001);
    arr(5'd31, 14'h0abc);
    arr(5'd6, FRW_BLANK);
    arr(5'd5, FRW_BLANK);
    arr(5'd7, FRW_BLANK);
    arr(5'd10, FRW_BLANK);
    load(5'd2, 14'h2aaa, 8'h06);
    arr(5'd0, 14'h1234);
    arr(5'd2, 14'h2aaa);
    // leftover latches would show up in the other row
    apb(1'b1, A_LO, 8'h43);
    apb(1'b1, D_LO, 8'h55);
    apb(1'b1, D_HI, 8'h15);
    trig(8'h06);
    arr_at(15'h0140, FRW_BLANK);
    arr_at(15'h0143, 14'h1555);
    arr(5'd3, FRW_BLANK);
    // copy of word 0 of the row taken through the data registers
    apb(1'b1, A_LO, 8'h20);
    apb(1'b1, CTL, 8'h05);
    rd(D_LO, 8'h34, "read back low");
    rd(D_HI, 8'h12, "read back high");
    apb(1'b1, CTL, 8'h34);
    trig(8'h36);
    arr(5'd0, FRW_BLANK);
    rd(CTL, 8'ha4, "erase flag cleared");
    load(5'd0, 14'h1234, 8'h06);
    arr(5'd0, 14'h1234);
    arr(5'd2, FRW_BLANK);
    finish_test();
  end
endmodule
